// ### design/ccr_core_control.sv
// Core control register bank with APB slave and priority, DSP and loop controls
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "ccr_map.svh"
// How it works
// R1: Software may read and clear the priority msb, never set it.
// R2: Priority level is the msb above the three status low bits.
// R3: Priority msb reads one for level eight or more, zero otherwise.
// R4: Program window enable maps program memory into data space.
// R5: Latency select picks variable bounded or fixed exception latency.
// R6: Stack frame active makes frame and stack pointers address the full page.
// R7: Single-bit sign mode: one unsigned, zero signed multiplies.
// R8: Two-bit sign mode: signed, unsigned, mixed; code three reserved.
// R9: Writing one to early terminate ends the loop after its iteration.
// R10: Early terminate always reads zero.
// R11: Loop depth field reports the number of active hardware loops.
// R12: Upper two depth bits are read-only on the classic variant.
// R13: First two nesting levels are kept entirely in hardware.
// R14: Each accumulator saturates only when its enable is one.
// R15: DSP writes to data space saturate when the write enable is set.
// R16: Saturation mode picks the 9.31 or 1.31 limit.
// R17: Rounding select picks biased or convergent rounding.
// R18: Integer select picks integer or fractional multiplies.
// R19: Unimplemented bits ignore writes and read zero.
// R20: User interrupts are blocked while the priority msb is one.
// R21: Trap entry sets the priority msb; exception return restores it.
module ccr_core_control
  import ccr_pkg::*;
#(
  parameter ccr_variant_e VARIANT = CCR_DSP_EXTENDED
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core status and exception events
  input  wire logic [2:0]  priority_level_low,
  input  wire logic        trap_entry,
  input  wire logic        exc_return,
  input  wire logic        restore_msb,
  input  wire logic        frame_link,
  input  wire logic        frame_unlink,
  // Hardware loop events
  input  wire logic        loop_start,
  input  wire logic        loop_end,
  input  wire logic        iter_done,
  // Priority controls
  output logic [3:0]       cpu_priority,
  output logic             user_irq_block,
  output logic             variable_latency_sel,
  // Address mapping controls
  output logic             program_space_window_en,
  output logic             stack_frame_active,
  // DSP engine modes
  output logic             mult_unsigned,
  output logic             mult_mixed,
  output logic             integer_mult_sel,
  output logic             rounding_sel,
  output logic             acc_a_sat_en,
  output logic             acc_b_sat_en,
  output logic             dsp_write_sat_en,
  output logic             acc_sat_mode,
  // Loop control
  output logic [2:0]       loop_nest_depth,
  output logic             loop_exit,
  output logic             loop_ctx_save
);
  logic [15:0] ctrl_r;
  logic        prio_msb_r;
  logic        frame_act_r;
  logic [31:0] prdata_r;
  logic        setup_ph;
  logic        access_ph;
  logic        hit_ctrl;
  logic        hit_prio;
  logic        wr_ctrl;
  logic [15:0] wdata;
  logic [15:0] ctrl_view;
  logic        dsp_var;

  // Readable bits per variant
  function automatic logic [15:0] rd_mask(input ccr_variant_e v);
    case (v)
      CCR_BASIC_MCU:    rd_mask = `CCR_RD_BASIC;
      CCR_EXTENDED_MCU: rd_mask = `CCR_RD_EXTMCU;
      CCR_DSP_CLASSIC:  rd_mask = `CCR_RD_DSPC;
      default:          rd_mask = `CCR_RD_DSPE;
    endcase
  endfunction

  // Software-writable bits per variant
  function automatic logic [15:0] wr_mask(input ccr_variant_e v);
    case (v)
      CCR_BASIC_MCU:    wr_mask = `CCR_WR_BASIC;
      CCR_EXTENDED_MCU: wr_mask = `CCR_WR_EXTMCU;
      CCR_DSP_CLASSIC:  wr_mask = `CCR_WR_DSPC;
      default:          wr_mask = `CCR_WR_DSPE;
    endcase
  endfunction

  // Bus phase decode
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_ctrl  = (paddr == `CCR_OFF_CTRL);
  assign hit_prio  = (paddr == `CCR_OFF_PRIO);
  assign wr_ctrl   = access_ph && pwrite && hit_ctrl;
  assign wdata     = pwdata[15:0];
  assign dsp_var   = (VARIANT == CCR_DSP_CLASSIC) || (VARIANT == CCR_DSP_EXTENDED);

  // Zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_ph && !(hit_ctrl || hit_prio);
  assign prdata  = prdata_r;

  // Plain control bits; unimplemented and status bits never store, except depth bit 8 on the classic variant
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `CCR_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wdata & wr_mask(VARIANT) & ~(16'h0001 << `CCR_B_TERM); // R19
  end

  // Priority msb: hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prio_msb_r <= 1'b0;
    else if (trap_entry)
      prio_msb_r <= 1'b1; // R21
    else if (exc_return)
      prio_msb_r <= restore_msb; // R21
    else if (wr_ctrl && !wdata[`CCR_B_PMSB])
      prio_msb_r <= 1'b0; // R1
  end

  // Stack frame state follows link and unlink; software cannot write it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_act_r <= 1'b0;
    else if (frame_link)
      frame_act_r <= 1'b1;
    else if (frame_unlink)
      frame_act_r <= 1'b0;
  end

  // Loop depth tracker; only the classic variant lets software touch bit 8
  ccr_loop_nest u_loop (
    .pclk         (pclk),
    .presetn      (presetn),
    .loop_start   (loop_start && dsp_var),
    .loop_end     (loop_end && dsp_var),
    .iter_done    (iter_done),
    .term_req     (wr_ctrl && dsp_var && wdata[`CCR_B_TERM]), // R9
    .lsb_we       (wr_ctrl && VARIANT == CCR_DSP_CLASSIC), // R12
    .lsb_val      (wdata[`CCR_B_DEPTH_LO]),
    .depth_r      (loop_nest_depth),
    .loop_exit_r  (loop_exit),
    .ctx_save_req (loop_ctx_save) // R13
  );

  // Assemble the readable view; early terminate is never shown
  always_comb
  begin
    ctrl_view = ctrl_r;
    ctrl_view[`CCR_B_PMSB] = prio_msb_r; // R3
    ctrl_view[`CCR_B_DEPTH_HI:`CCR_B_DEPTH_LO] = loop_nest_depth; // R11
    ctrl_view[`CCR_B_TERM] = 1'b0; // R10
    if (VARIANT == CCR_EXTENDED_MCU || VARIANT == CCR_DSP_EXTENDED)
      ctrl_view[`CCR_B_WIN_FRAME] = frame_act_r;
    ctrl_view = ctrl_view & rd_mask(VARIANT); // R19
  end

  // Read data captured in the setup cycle, held through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (setup_ph && !pwrite && hit_ctrl)
      prdata_r <= {16'h0000, ctrl_view};
    else if (setup_ph && !pwrite && hit_prio)
      prdata_r <= {27'h0, prio_msb_r, cpu_priority};
    else if (setup_ph)
      prdata_r <= 32'h00000000;
  end

  // Priority level and interrupt gating
  assign cpu_priority   = {prio_msb_r, priority_level_low}; // R2
  assign user_irq_block = prio_msb_r; // R20

  // Mode outputs per variant
  assign variable_latency_sel = (VARIANT == CCR_EXTENDED_MCU || VARIANT == CCR_DSP_EXTENDED)
                                && ctrl_r[`CCR_B_VAR]; // R5
  assign program_space_window_en = (VARIANT == CCR_BASIC_MCU || VARIANT == CCR_DSP_CLASSIC)
                                   && ctrl_r[`CCR_B_WIN_FRAME]; // R4
  assign stack_frame_active = (VARIANT == CCR_EXTENDED_MCU || VARIANT == CCR_DSP_EXTENDED)
                              && frame_act_r; // R6

  // Multiplier sign decoding; the reserved code falls back to signed
  always_comb
  begin
    mult_unsigned = 1'b0;
    mult_mixed    = 1'b0;
    if (VARIANT == CCR_DSP_CLASSIC)
      mult_unsigned = ctrl_r[`CCR_B_SIGN_LO]; // R7
    else if (VARIANT == CCR_DSP_EXTENDED)
    begin
      mult_unsigned = (ctrl_r[`CCR_B_SIGN_HI:`CCR_B_SIGN_LO] == 2'h1); // R8
      mult_mixed    = (ctrl_r[`CCR_B_SIGN_HI:`CCR_B_SIGN_LO] == 2'h2); // R8
    end
  end

  // DSP engine enables, zero on the plain controller variants
  assign acc_a_sat_en     = dsp_var && ctrl_r[`CCR_B_SAT_A]; // R14
  assign acc_b_sat_en     = dsp_var && ctrl_r[`CCR_B_SAT_B]; // R14
  assign dsp_write_sat_en = dsp_var && ctrl_r[`CCR_B_WSAT]; // R15
  assign acc_sat_mode     = dsp_var && ctrl_r[`CCR_B_SATMODE]; // R16
  assign rounding_sel     = dsp_var && ctrl_r[`CCR_B_ROUND]; // R17
  assign integer_mult_sel = dsp_var && ctrl_r[`CCR_B_IF]; // R18

  // Checks

  sequence s_sw_clear;
    wr_ctrl && !wdata[`CCR_B_PMSB] && !trap_entry && !exc_return;
  endsequence

  sequence s_trap;
    trap_entry;
  endsequence

  chk_msb_no_set: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (!prio_msb_r && !trap_entry && !exc_return) |=> !prio_msb_r)
    else $error("priority msb rose without a trap");

  chk_msb_sw_clear: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    s_sw_clear |=> !prio_msb_r)
    else $error("software clear of priority msb lost");

  chk_level_concat: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    cpu_priority[2:0] == priority_level_low && cpu_priority[3] == prio_msb_r)
    else $error("priority level not formed from msb and low bits");

  chk_trap_sets_msb: assert property ( // R21
    @(posedge pclk) disable iff (!presetn)
    s_trap |=> (prio_msb_r && cpu_priority >= 4'h8) ##1 (user_irq_block || !prio_msb_r))
    else $error("trap did not raise the priority above seven");

  chk_irq_block: assert property ( // R20
    @(posedge pclk) disable iff (!presetn)
    $rose(prio_msb_r) |-> user_irq_block)
    else $error("user interrupts not blocked at raised priority");

  chk_term_reads_zero: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_ctrl) |=> !prdata[`CCR_B_TERM])
    else $error("early terminate bit read back as one");

  chk_unimpl_zero: assert property ( // R19
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_ctrl) |=> (prdata[15:0] & ~rd_mask(VARIANT)) == 16'h0000)
    else $error("unimplemented bit read as one");

  chk_sat_a_follow: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var) |=> acc_a_sat_en == $past(wdata[`CCR_B_SAT_A]))
    else $error("accumulator A saturation enable did not follow write");

  chk_mult_mode: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (VARIANT == CCR_DSP_EXTENDED && wr_ctrl) |=>
      (mult_mixed == ($past(wdata[`CCR_B_SIGN_HI:`CCR_B_SIGN_LO]) == 2'h2)) && !(mult_mixed && mult_unsigned))
    else $error("multiplier sign mode decode wrong");

  chk_term_exit: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var && wdata[`CCR_B_TERM] && loop_nest_depth != 3'h0
     && !iter_done && !loop_end && !loop_start) ##1 (!iter_done && !loop_start && !loop_end)
     ##1 (iter_done && loop_nest_depth != 3'h0 && !loop_start && !loop_end)
      |=> loop_exit ##0 (loop_nest_depth == $past(loop_nest_depth) - 3'h1))
    else $error("early loop termination did not end the loop");

  chk_depth_hw_save: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    (loop_start && dsp_var && loop_nest_depth < `CCR_HW_LEVELS) |-> !loop_ctx_save)
    else $error("context save requested inside hardware levels");

  chk_slverr_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && (hit_ctrl || hit_prio)) |-> !pslverr)
    else $error("mapped register answered with an error");

  chk_window_follow: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && (VARIANT == CCR_BASIC_MCU || VARIANT == CCR_DSP_CLASSIC))
      |=> program_space_window_en == $past(wdata[`CCR_B_WIN_FRAME]))
    else $error("program window enable did not follow write");

  chk_latency_follow: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && (VARIANT == CCR_EXTENDED_MCU || VARIANT == CCR_DSP_EXTENDED))
      |=> variable_latency_sel == $past(wdata[`CCR_B_VAR]))
    else $error("latency select did not follow write");

  chk_frame_hold: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    (!frame_link && !frame_unlink) |=> $stable(stack_frame_active))
    else $error("stack frame flag moved without a link event");

  chk_sign_single: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && VARIANT == CCR_DSP_CLASSIC)
      |=> mult_unsigned == $past(wdata[`CCR_B_SIGN_LO]) && !mult_mixed)
    else $error("single-bit sign mode decode wrong");

  chk_wsat_follow: assert property ( // R15
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var) |=> dsp_write_sat_en == $past(wdata[`CCR_B_WSAT]))
    else $error("data write saturation enable did not follow write");

  chk_satmode_follow: assert property ( // R16
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var) |=> acc_sat_mode == $past(wdata[`CCR_B_SATMODE]))
    else $error("saturation mode did not follow write");

  chk_round_follow: assert property ( // R17
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var) |=> rounding_sel == $past(wdata[`CCR_B_ROUND]))
    else $error("rounding select did not follow write");

  chk_int_follow: assert property ( // R18
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && dsp_var) |=> integer_mult_sel == $past(wdata[`CCR_B_IF]))
    else $error("integer select did not follow write");

  chk_depth_ro: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !loop_start && !loop_end && !iter_done)
      |=> loop_nest_depth[2:1] == $past(loop_nest_depth[2:1]))
    else $error("software changed the upper loop depth bits");
endmodule

// ### design/ccr_loop_nest.sv
// Hardware loop nesting depth tracker with early termination
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_loop_nest
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Loop events from the sequencer
  input  wire logic       loop_start,
  input  wire logic       loop_end,
  input  wire logic       iter_done,
  // Software controls
  input  wire logic       term_req,
  input  wire logic       lsb_we,
  input  wire logic       lsb_val,
  // Status
  output logic [2:0]      depth_r,
  output logic            loop_exit_r,
  output logic            ctx_save_req
);
  ccr_term_state_e state_r;
  ccr_term_state_e state_nxt;
  logic            exit_now;

  // Termination waits for the running iteration to finish
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LT_IDLE:
        if (term_req && depth_r != 3'h0)
          state_nxt = LT_PENDING;
      LT_PENDING:
        if (iter_done || depth_r == 3'h0)
          state_nxt = LT_IDLE;
      default:
        state_nxt = LT_IDLE;
    endcase
  end

  assign exit_now = (state_r == LT_PENDING) && iter_done && depth_r != 3'h0; // R9

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= LT_IDLE;
    else
      state_r <= state_nxt;
  end

  // Exit pulse to the loop sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_exit_r <= 1'b0;
    else
      loop_exit_r <= exit_now; // R9
  end

  // Depth count saturates at seven; a forced exit counts as a loop end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      depth_r <= 3'h0;
    else if (loop_start && !(loop_end || exit_now) && depth_r != `CCR_DEPTH_MAX)
      depth_r <= depth_r + 3'h1; // R11
    else if ((loop_end || exit_now) && !loop_start && depth_r != 3'h0)
      depth_r <= depth_r - 3'h1; // R11
    else if (lsb_we)
      depth_r <= {depth_r[2:1], lsb_val}; // R12
  end

  // Levels beyond the hardware-held ones need a software context save
  assign ctx_save_req = loop_start && (depth_r >= `CCR_HW_LEVELS); // R13
endmodule

// ### design/ccr_map.svh
// Offsets, field positions, masks and reset values of the core control block
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register byte offsets
`define CCR_OFF_CTRL      12'h000
`define CCR_OFF_PRIO      12'h004

// Control register field positions
`define CCR_B_VAR         15
`define CCR_B_SIGN_HI     13
`define CCR_B_SIGN_LO     12
`define CCR_B_TERM        11
`define CCR_B_DEPTH_HI    10
`define CCR_B_DEPTH_LO    8
`define CCR_B_SAT_A       7
`define CCR_B_SAT_B       6
`define CCR_B_WSAT        5
`define CCR_B_SATMODE     4
`define CCR_B_PMSB        3
`define CCR_B_WIN_FRAME   2
`define CCR_B_ROUND       1
`define CCR_B_IF          0

// Readable and software-writable masks per variant
`define CCR_RD_BASIC      16'h000C
`define CCR_WR_BASIC      16'h0004
`define CCR_RD_EXTMCU     16'h800C
`define CCR_WR_EXTMCU     16'h8000
`define CCR_RD_DSPC       16'h17FF
`define CCR_WR_DSPC       16'h19F7
`define CCR_RD_DSPE       16'hB7FF
`define CCR_WR_DSPE       16'hB8F3

// Reset value and loop depth limits
`define CCR_CTRL_RST      16'h0000
`define CCR_DEPTH_MAX     3'h7
`define CCR_HW_LEVELS     3'h2

`endif

// ### design/ccr_pkg.sv
// Types shared by the core control block
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_BASIC_MCU,
    CCR_EXTENDED_MCU,
    CCR_DSP_CLASSIC,
    CCR_DSP_EXTENDED
  } ccr_variant_e;

  typedef enum logic {
    LT_IDLE,
    LT_PENDING
  } ccr_term_state_e;
endpackage

// ### tb/ccr_core_control_tb.sv
// Self-checking bench for the core control register bank over APB
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_core_control_tb
  import ccr_pkg::*;
;
  // Clock, reset and APB master signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        psel_c = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0]  priority_level_low = 3'h5;
  logic        restore_msb = 1'b0;
  logic        trap_entry = 1'b0;
  logic        exc_return = 1'b0;
  logic        frame_link = 1'b0;
  logic        frame_unlink = 1'b0;
  logic        loop_start = 1'b0;
  logic        loop_end = 1'b0;
  logic        iter_done = 1'b0;
  // Outputs of both instances
  logic [31:0] prdata;
  logic [31:0] prdata_c;
  logic        pready;
  logic        pready_c;
  logic        pslverr;
  logic        pslverr_c;
  logic [3:0]  cpu_priority;
  logic        user_irq_block;
  logic        variable_latency_sel;
  logic        program_space_window_en;
  logic        program_space_window_en_c;
  logic        stack_frame_active;
  logic        mult_unsigned;
  logic        mult_unsigned_c;
  logic        mult_mixed;
  logic        integer_mult_sel;
  logic        rounding_sel;
  logic        acc_a_sat_en;
  logic        acc_b_sat_en;
  logic        dsp_write_sat_en;
  logic        acc_sat_mode;
  logic [2:0]  loop_nest_depth;
  logic        loop_exit;
  logic        loop_ctx_save;
  logic        ctx_seen;
  logic [31:0] modes;
  int          fail_count = 0;
  int          n_tests = 0;
  int          k;
  logic [31:0] v;
  logic        e;
  // Walking writes on the extended variant and the mode vector each one should raise
  logic [15:0] wv [10] = '{16'h8000, 16'h1000, 16'h2000, 16'h3000, 16'h0080,
                           16'h0040, 16'h0020, 16'h0010, 16'h0002, 16'h0001};
  logic [8:0]  mv [10] = '{9'h100, 9'h080, 9'h040, 9'h000, 9'h008,
                           9'h004, 9'h002, 9'h001, 9'h010, 9'h020};

  // Latency select and DSP mode outputs packed for one compare
  assign modes = {23'h0, variable_latency_sel, mult_unsigned, mult_mixed, integer_mult_sel, rounding_sel,
                  acc_a_sat_en, acc_b_sat_en, dsp_write_sat_en, acc_sat_mode};

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // Extended variant is the main target; classic shares the bus but has its own select
  ccr_core_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .priority_level_low(priority_level_low), .trap_entry(trap_entry), .exc_return(exc_return),
    .restore_msb(restore_msb), .frame_link(frame_link), .frame_unlink(frame_unlink),
    .loop_start(loop_start), .loop_end(loop_end), .iter_done(iter_done), .cpu_priority(cpu_priority),
    .user_irq_block(user_irq_block), .variable_latency_sel(variable_latency_sel),
    .program_space_window_en(program_space_window_en), .stack_frame_active(stack_frame_active),
    .mult_unsigned(mult_unsigned), .mult_mixed(mult_mixed), .integer_mult_sel(integer_mult_sel),
    .rounding_sel(rounding_sel), .acc_a_sat_en(acc_a_sat_en), .acc_b_sat_en(acc_b_sat_en),
    .dsp_write_sat_en(dsp_write_sat_en), .acc_sat_mode(acc_sat_mode), .loop_nest_depth(loop_nest_depth),
    .loop_exit(loop_exit), .loop_ctx_save(loop_ctx_save));

  ccr_core_control #(.VARIANT(CCR_DSP_CLASSIC)) dut_c (.pclk(pclk), .presetn(presetn), .psel(psel_c),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_c),
    .pready(pready_c), .pslverr(pslverr_c), .priority_level_low(priority_level_low),
    .trap_entry(trap_entry), .exc_return(exc_return), .restore_msb(restore_msb), .frame_link(frame_link),
    .frame_unlink(frame_unlink), .loop_start(loop_start), .loop_end(loop_end), .iter_done(iter_done),
    .cpu_priority(), .user_irq_block(), .variable_latency_sel(),
    .program_space_window_en(program_space_window_en_c), .stack_frame_active(), .mult_unsigned(mult_unsigned_c),
    .mult_mixed(), .integer_mult_sel(), .rounding_sel(), .acc_a_sat_en(), .acc_b_sat_en(),
    .dsp_write_sat_en(), .acc_sat_mode(), .loop_nest_depth(), .loop_exit(), .loop_ctx_save());

  // Compare one value and count it
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic c, input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= ~c;
    psel_c  <= c;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while ((c ? pready_c : pready) !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      fail_count++;
      give_verdict();
    end
    else
    begin
      rd = c ? prdata_c : prdata;
      err = c ? pslverr_c : pslverr;
      psel    <= 1'b0;
      psel_c  <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Write, then move to a settled point for output checks
  task automatic wr(input logic c, input logic [11:0] a, input logic [31:0] d);
    apb(c, 1'b1, a, d, v, e);
    @(negedge pclk);
  endtask

  task automatic rd(input logic c, input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(c, 1'b0, a, 32'h0, v, e);
    chk(name, v, exp);
  endtask

  // One-cycle event pulse; ctx save is combinational so it is caught mid-pulse
  task automatic ev(input logic [6:0] m);
    @(posedge pclk);
    {trap_entry, exc_return, frame_link, frame_unlink, loop_start, loop_end, iter_done} <= m;
    @(negedge pclk);
    ctx_seen = loop_ctx_save;
    @(posedge pclk);
    {trap_entry, exc_return, frame_link, frame_unlink, loop_start, loop_end, iter_done} <= 7'h00;
    @(negedge pclk);
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("prio_rst", {28'h0, cpu_priority}, 32'h5);
    chk("modes_rst", modes, 32'h0);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0, "ctrl_rst");
    // Classic variant: low depth bit, window enable and single-bit sign mode
    wr(1'b1, `CCR_OFF_CTRL, 32'hFFFF);
    rd(1'b1, `CCR_OFF_CTRL, 32'h11F7, "ctrl_c");
    chk("win_c", {31'h0, program_space_window_en_c}, 32'h1);
    chk("sign_c", {31'h0, mult_unsigned_c}, 32'h1);
    wr(1'b1, `CCR_OFF_CTRL, 32'h0000);
    chk("win_c0", {31'h0, program_space_window_en_c}, 32'h0);
    chk("sign_c0", {31'h0, mult_unsigned_c}, 32'h0);
    // Each writable mode bit alone, and every sign code
    for (k = 0; k < 10; k++)
    begin
      wr(1'b0, `CCR_OFF_CTRL, {16'h0, wv[k]});
      rd(1'b0, `CCR_OFF_CTRL, {16'h0, wv[k]}, "ctrl_walk");
      chk("modes_walk", modes, {23'h0, mv[k]});
    end
    // All ones: unimplemented, terminate and msb bits stay zero
    wr(1'b0, `CCR_OFF_CTRL, 32'hFFFF);
    rd(1'b0, `CCR_OFF_CTRL, 32'hB0F3, "ctrl_ones");
    chk("modes_ones", modes, 32'h13F);
    chk("prio_ones", {28'h0, cpu_priority}, 32'h5);
    wr(1'b0, `CCR_OFF_CTRL, 32'h0000);
    // Trap raises the msb; software may clear but not set it
    ev(7'h40);
    chk("prio_trap", {28'h0, cpu_priority}, 32'hD);
    chk("blk_trap", {31'h0, user_irq_block}, 32'h1);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0008, "ctrl_trap");
    rd(1'b0, `CCR_OFF_PRIO, 32'h1D, "stat_trap");
    wr(1'b0, `CCR_OFF_CTRL, 32'h0008);
    chk("prio_set", {28'h0, cpu_priority}, 32'hD);
    wr(1'b0, `CCR_OFF_CTRL, 32'h0000);
    chk("prio_clr", {28'h0, cpu_priority}, 32'h5);
    chk("blk_clr", {31'h0, user_irq_block}, 32'h0);
    // Exception return restores the saved msb either way
    ev(7'h40);
    ev(7'h20);
    chk("ret0", {31'h0, user_irq_block}, 32'h0);
    @(posedge pclk) restore_msb <= 1'b1;
    ev(7'h20);
    chk("ret1", {28'h0, cpu_priority}, 32'hD);
    wr(1'b0, `CCR_OFF_CTRL, 32'h0000);
    // Unmapped address errors; status register ignores writes without error
    apb(1'b0, 1'b0, 12'h008, 32'h0, v, e);
    chk("unm_err", {31'h0, e}, 32'h1);
    chk("unm_data", v, 32'h0);
    apb(1'b0, 1'b1, 12'h008, 32'hFFFF, v, e);
    chk("unm_werr", {31'h0, e}, 32'h1);
    apb(1'b0, 1'b1, `CCR_OFF_PRIO, 32'hFFFF, v, e);
    chk("ro_err", {31'h0, e}, 32'h0);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0, "ctrl_unm");
    // Stack frame flag follows link events, not software
    ev(7'h10);
    chk("frame_on", {31'h0, stack_frame_active}, 32'h1);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0004, "ctrl_frame");
    wr(1'b0, `CCR_OFF_CTRL, 32'h0000);
    chk("frame_ro", {31'h0, stack_frame_active}, 32'h1);
    ev(7'h08);
    chk("frame_off", {31'h0, stack_frame_active}, 32'h0);
    // Nesting depth; third level spills context
    ev(7'h04);
    ev(7'h04);
    chk("ctx_lvl2", {31'h0, ctx_seen}, 32'h0);
    ev(7'h04);
    chk("ctx_lvl3", {31'h0, ctx_seen}, 32'h1);
    wr(1'b0, `CCR_OFF_CTRL, 32'h0700);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0300, "depth3");
    ev(7'h06);
    chk("both", {29'h0, loop_nest_depth}, 32'h3);
    // Early terminate takes effect at the end of the iteration
    wr(1'b0, `CCR_OFF_CTRL, 32'h0800);
    chk("term_wait", {31'h0, loop_exit}, 32'h0);
    ev(7'h01);
    chk("term_exit", {31'h0, loop_exit}, 32'h1);
    chk("term_depth", {29'h0, loop_nest_depth}, 32'h2);
    @(negedge pclk);
    chk("exit_pulse", {31'h0, loop_exit}, 32'h0);
    rd(1'b0, `CCR_OFF_CTRL, 32'h0200, "term_read");
    // Ends floor at zero, starts saturate at seven
    for (k = 0; k < 3; k++)
      ev(7'h02);
    chk("floor", {29'h0, loop_nest_depth}, 32'h0);
    for (k = 0; k < 8; k++)
      ev(7'h04);
    chk("sat", {29'h0, loop_nest_depth}, 32'h7);
    // Writing zero to terminate does nothing
    wr(1'b0, `CCR_OFF_CTRL, 32'h0000);
    ev(7'h01);
    chk("term_zero", {31'h0, loop_exit}, 32'h0);
    chk("term_zdep", {29'h0, loop_nest_depth}, 32'h7);
    give_verdict();
  end
endmodule
